// File: rtl/pmws_pkg.sv
// package of the power mode and wake sequencer
// assumes one 250 MHz clock; figures below are in cycles of it unless their name ends in NS
package pmws_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    // internal rc oscillator start-up after power-down (least time, round up)
    localparam int IRC_START_NS = 60000;
    localparam int IRC_START_CYC = (IRC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // flash start-up after power-down (least time, round up)
    localparam int FLASH_WAKE_NS = 100000;
    localparam int FLASH_WAKE_CYC = (FLASH_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // resume delay when the rc oscillator ran before sleep
    localparam int IRC_RESUME_CYC = 4;
    // resume delay when the main oscillator ran before sleep
    localparam int OSC_RESUME_CYC = 4096;
    // fixed hold count of the reset wake-up timer
    localparam int RST_HOLD_CYC = 64;
    localparam int CNT_W = 16;

    // ****************************************
    // sleep mode codes from the processor
    // ****************************************
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_DSLEEP = 2'h1;
    localparam logic [1:0] MODE_PDOWN = 2'h2;

    // first fetch address after internal reset
    localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;

    // synchroniser bit positions of the pin inputs
    localparam int PIN_EXT_RST_N = 0;
    localparam int PIN_WDT = 1;
    localparam int PIN_BOD1 = 2;
    localparam int PIN_BOD2 = 3;
    localparam int PIN_OSC_RUN = 4;
    localparam int PIN_FLASH_DONE = 5;
    localparam int PIN_RTC_ALARM = 6;
    localparam int PIN_RTC_DPD = 7;
    localparam int PIN_W = 8;

    typedef enum logic [2:0] {
        ST_RST,
        ST_RUN,
        ST_SLEEP,
        ST_DSLP,
        ST_PDN,
        ST_DPD,
        ST_IRCUP,
        ST_RESUME
    } pmws_state_type;

endpackage

// File: rtl/pmws_wake_catcher.sv
// wake interrupt catcher: holds the mask handed over at sleep entry
// assumes irq lines are asynchronous pins; capture and arm come from clk logic
`timescale 1ns/100ps
module pmws_wake_catcher #(
    parameter int N_IRQ = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [N_IRQ-1:0] irq_raw,
    input wire logic capture,
    input wire logic [N_IRQ-1:0] mask_in,
    input wire logic armed,
    output logic wake
);

    // ****************************************
    // synchroniser and mask
    // ****************************************
    logic [N_IRQ-1:0] irq_meta_q, irq_s_q;
    logic [N_IRQ-1:0] mask_q, mask_d;
    logic wake_q, wake_d;

    // next values: mask latched once per entry, hit seen without polling
    always_comb begin
        mask_d = capture ? mask_in : mask_q;
        wake_d = armed && !capture && |(irq_s_q & mask_q);
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_meta_q <= '0;
            irq_s_q <= '0;
            mask_q <= '0;
            wake_q <= 1'b0;
        end else begin
            irq_meta_q <= irq_raw;
            irq_s_q <= irq_meta_q;
            mask_q <= mask_d;
            wake_q <= wake_d;
        end
    end

    assign wake = wake_q;

    property p_hit_wakes;
        @(posedge clk) disable iff (reset)
        armed && !capture && |(irq_s_q & mask_q) |=> wake;
    endproperty
    a_hit_wakes: assert property (p_hit_wakes) else $error("masked irq did not wake");

    property p_no_spurious;
        @(posedge clk) disable iff (reset)
        wake |-> $past(armed) && $past(|(irq_s_q & mask_q));
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("wake without masked irq");

endmodule

// File: rtl/pmws_top.sv
// power mode and wake sequencer: reset gathering, sleep entry, wake timing
// assumes processor-side inputs are on clk; pin and analog flags are asynchronous
//
// Functional notes
// - deep-sleep stops clocks, gates rc output
// - deep-sleep entry turns pll off, disconnected
// - deep-sleep entry clears cpu, usb dividers
// - deep-sleep exits only on reset, clockless irq
// - flash stays powered in deep-sleep
// - rc prior source resumes after 4 cycles
// - main oscillator prior source waits 4096 cycles
// - power-down also cuts rc and flash power
// - power-down wake: 60 us start, then 4 or 4096 cycles by prior source
// - flash blocked until 100 us counter expires
// - deep power-down entered only from rtc
// - deep power-down exits on reset pin, alarm
// - interrupt controller hands mask at entry
// - masked interrupt wakes without polling
// - four reset sources combine into chip reset
// - any reset source drives reset-out low
// - reset held until pin, oscillator, count, flash
// - reset-out high after release and brownout recovery
// - after reset fetch starts at address zero
// - first brownout stage raises irq and status
// - second brownout stage holds chip reset
// - rc oscillator selected after power-up, power-down
`timescale 1ns/100ps
module pmws_top
    import pmws_pkg::*;
#(
    parameter int N_IRQ = 32,
    parameter int IRC_START_CYCLES = IRC_START_CYC,
    parameter int FLASH_WAKE_CYCLES = FLASH_WAKE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ext_reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic brownout_stage1,
    input wire logic brownout_stage2,
    input wire logic osc_running,
    input wire logic flash_init_done,
    input wire logic rtc_alarm,
    input wire logic rtc_dpd_req,
    input wire logic [N_IRQ-1:0] irq_lines,
    input wire logic sleep_req,
    input wire logic [1:0] sleep_mode,
    input wire logic [N_IRQ-1:0] wake_mask,
    input wire logic sel_main_osc,
    input wire logic pll_reconfig,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic irc_out_en,
    output logic irc_power_en,
    output logic main_osc_en,
    output logic pll_shutdown,
    output logic cpu_div_clear,
    output logic usb_div_clear,
    output logic flash_power_en,
    output logic flash_access_en,
    output logic core_power_en,
    output logic core_reset,
    output logic reset_out_pin,
    output logic cpu_wake,
    output logic bod_irq,
    output logic bod_status,
    output logic clk_sel_irc,
    output logic [31:0] boot_vector
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [PIN_W-1:0] pin_meta_q, pin_s_q;
    logic rst_src, wake_hit;

    // external reset pin idles low here, so the chip sits in reset until it syncs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_meta_q <= '0;
            pin_s_q <= '0;
        end else begin
            pin_meta_q <= {rtc_dpd_req, rtc_alarm, flash_init_done, osc_running,
                           brownout_stage2, brownout_stage1, watchdog_reset, ext_reset_pin_n};
            pin_s_q <= pin_meta_q;
        end
    end

    // por is the async reset itself; the other three come through here
    assign rst_src = !pin_s_q[PIN_EXT_RST_N] || pin_s_q[PIN_WDT] || pin_s_q[PIN_BOD2];

    // ****************************************
    // sequencer state machine
    // ****************************************
    pmws_state_type state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic resume_main_q, resume_main_d;
    logic capture;
    logic [CNT_W-1:0] hold_lim;

    // resume delay depends on the clock source in use before sleep
    assign hold_lim = resume_main_q ? CNT_W'(OSC_RESUME_CYC - 1) : CNT_W'(IRC_RESUME_CYC - 1);

    // next state; a reset source overrides every other request
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        resume_main_d = resume_main_q;
        case (state_q)
            ST_RST: begin
                if (cnt_q != CNT_W'(RST_HOLD_CYC)) begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
                if (pin_s_q[PIN_OSC_RUN] && pin_s_q[PIN_FLASH_DONE] && cnt_q == CNT_W'(RST_HOLD_CYC)) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                cnt_d = '0;
                resume_main_d = !clk_sel_irc;
                if (pin_s_q[PIN_RTC_DPD]) begin
                    state_d = ST_DPD;
                end else if (sleep_req) begin
                    case (sleep_mode)
                        MODE_SLEEP: state_d = ST_SLEEP;
                        MODE_DSLEEP: state_d = ST_DSLP;
                        MODE_PDOWN: state_d = ST_PDN;
                        default: state_d = ST_RUN;
                    endcase
                end
            end
            // a masked irq leaves the sleep states; the reset pin leaves dpd through the override below
            ST_SLEEP: if (wake_hit) state_d = ST_RUN;
            ST_DSLP: if (wake_hit) state_d = ST_RESUME;
            ST_PDN: if (wake_hit) state_d = ST_IRCUP;
            ST_DPD: if (pin_s_q[PIN_RTC_ALARM]) state_d = ST_RST;
            ST_IRCUP: begin
                cnt_d = cnt_q + CNT_W'(1);
                if (cnt_q == CNT_W'(IRC_START_CYCLES - 1)) begin
                    state_d = ST_RESUME;
                    cnt_d = '0;
                end
            end
            ST_RESUME: begin
                cnt_d = cnt_q + CNT_W'(1);
                if (cnt_q == hold_lim) begin
                    state_d = ST_RUN;
                    cnt_d = '0;
                end
            end
            default: state_d = ST_RST;
        endcase
        if (rst_src) begin
            state_d = ST_RST;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_RST;
            cnt_q <= '0;
            resume_main_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            resume_main_q <= resume_main_d;
        end
    end

    // mask handed over on every way out of run into a low-power state
    assign capture = state_q == ST_RUN && state_d != ST_RUN && state_d != ST_RST;

    // ****************************************
    // wake interrupt catcher
    // ****************************************
    pmws_wake_catcher #(
        .N_IRQ(N_IRQ)
    ) u_catcher (
        .clk(clk),
        .reset(reset),
        .irq_raw(irq_lines),
        .capture(capture),
        .mask_in(wake_mask),
        .armed(state_q == ST_SLEEP || state_q == ST_DSLP || state_q == ST_PDN),
        .wake(wake_hit)
    );

    // ****************************************
    // clock, power and reset controls
    // ****************************************
    logic [12:0] ctl_q, ctl_d;
    logic deep_d, deep_entry;

    assign deep_d = state_d == ST_DSLP || state_d == ST_PDN || state_d == ST_DPD;
    assign deep_entry = deep_d && !(state_q == ST_DSLP || state_q == ST_PDN || state_q == ST_DPD);

    // controls follow the next state so they line up with state_q
    always_comb begin
        ctl_d[0] = state_d == ST_RUN;
        ctl_d[1] = state_d == ST_RUN || state_d == ST_SLEEP;
        ctl_d[2] = !deep_d && state_d != ST_IRCUP;
        ctl_d[3] = state_d != ST_PDN && state_d != ST_DPD;
        ctl_d[4] = !deep_d && state_d != ST_IRCUP && !(state_d == ST_RESUME && !resume_main_q);
        ctl_d[5] = deep_entry;
        ctl_d[6] = deep_entry;
        ctl_d[7] = state_d != ST_PDN && state_d != ST_DPD;
        ctl_d[8] = state_d != ST_DPD;
        ctl_d[9] = state_d == ST_RST || state_d == ST_DPD;
        ctl_d[10] = state_d != ST_RST && !pin_s_q[PIN_BOD2];
        ctl_d[11] = pin_s_q[PIN_BOD1];
        ctl_d[12] = state_d == ST_RUN;
    end

    // after reset only rc power and core reset are on and reset-out is low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctl_q <= 13'h0208;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign cpu_clk_en = ctl_q[0];
    assign periph_clk_en = ctl_q[1];
    assign irc_out_en = ctl_q[2];
    assign irc_power_en = ctl_q[3];
    assign main_osc_en = ctl_q[4];
    assign cpu_div_clear = ctl_q[5];
    assign usb_div_clear = ctl_q[6];
    assign flash_power_en = ctl_q[7];
    assign core_power_en = ctl_q[8];
    assign core_reset = ctl_q[9];
    assign reset_out_pin = ctl_q[10];
    assign bod_irq = ctl_q[11];
    assign bod_status = ctl_q[11];
    assign cpu_wake = ctl_q[12];
    assign boot_vector = BOOT_VECTOR;

    // ****************************************
    // pll, clock select and flash wake timer
    // ****************************************
    logic pll_off_q, pll_off_d;
    logic irc_sel_q, irc_sel_d;
    logic flash_wait_q, flash_wait_d;
    logic flash_ready_q, flash_ready_d;
    logic [CNT_W-1:0] flash_cnt_q, flash_cnt_d;

    // pll stays off until software rebuilds it; a new shutdown wins over reconfig
    always_comb begin
        pll_off_d = pll_off_q;
        if (pll_reconfig) begin
            pll_off_d = 1'b0;
        end
        if (deep_entry || state_d == ST_RST) begin
            pll_off_d = 1'b1;
        end
        irc_sel_d = irc_sel_q;
        if (sel_main_osc) begin
            irc_sel_d = 1'b0;
        end
        if (state_d == ST_RST || state_d == ST_IRCUP) begin
            irc_sel_d = 1'b1;
        end
        flash_wait_d = flash_wait_q;
        flash_ready_d = flash_ready_q;
        flash_cnt_d = '0;
        if (state_d == ST_RST || state_d == ST_PDN || state_d == ST_DPD) begin
            flash_ready_d = 1'b0;
            flash_wait_d = state_d == ST_PDN;
        end else if (flash_wait_q) begin
            flash_cnt_d = flash_cnt_q + CNT_W'(1);
            if (flash_cnt_q == CNT_W'(FLASH_WAKE_CYCLES - 1)) begin
                flash_wait_d = 1'b0;
                flash_ready_d = 1'b1;
            end
        end else if (state_q == ST_RST) begin
            flash_ready_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pll_off_q <= 1'b1;
            irc_sel_q <= 1'b1;
            flash_wait_q <= 1'b0;
            flash_ready_q <= 1'b0;
            flash_cnt_q <= '0;
        end else begin
            pll_off_q <= pll_off_d;
            irc_sel_q <= irc_sel_d;
            flash_wait_q <= flash_wait_d;
            flash_ready_q <= flash_ready_d;
            flash_cnt_q <= flash_cnt_d;
        end
    end

    assign pll_shutdown = pll_off_q;
    assign clk_sel_irc = irc_sel_q;
    // flash wait only starts counting once the pd state is left
    assign flash_access_en = flash_ready_q && !core_reset;

    // ****************************************
    // checks
    // ****************************************
    property p_bod2_reset;
        @(posedge clk) disable iff (reset)
        pin_s_q[PIN_BOD2] |=> core_reset && !reset_out_pin;
    endproperty
    a_bod2_reset: assert property (p_bod2_reset) else $error("brownout did not hold reset");
    property p_src_reset;
        @(posedge clk) disable iff (reset)
        rst_src |=> core_reset && !reset_out_pin && !cpu_clk_en;
    endproperty
    a_src_reset: assert property (p_src_reset) else $error("reset source ignored");
    property p_release;
        @(posedge clk) disable iff (reset)
        $fell(core_reset) && $past(state_q) == ST_RST
            |-> $past(pin_s_q[PIN_OSC_RUN]) && $past(pin_s_q[PIN_FLASH_DONE]) && reset_out_pin;
    endproperty
    a_release: assert property (p_release) else $error("reset released too early");
    property p_deep_pll;
        @(posedge clk) disable iff (reset)
        state_q == ST_DSLP |-> pll_shutdown && !cpu_clk_en && !irc_out_en && irc_power_en && flash_power_en;
    endproperty
    a_deep_pll: assert property (p_deep_pll) else $error("deep-sleep controls wrong");
    property p_div_clear;
        @(posedge clk) disable iff (reset)
        state_q == ST_RUN && state_d == ST_DSLP && !rst_src |=> cpu_div_clear && usb_div_clear ##1 !cpu_div_clear;
    endproperty
    a_div_clear: assert property (p_div_clear) else $error("divider clear missing");
    property p_irc_resume;
        @(posedge clk) disable iff (reset || rst_src)
        $rose(state_q == ST_RESUME) && !resume_main_q |-> !cpu_clk_en [*4] ##1 cpu_clk_en;
    endproperty
    a_irc_resume: assert property (p_irc_resume) else $error("rc resume not 4 cycles");
    property p_osc_resume;
        @(posedge clk) disable iff (reset)
        $rose(cpu_clk_en) && $past(state_q) == ST_RESUME && $past(resume_main_q)
            |-> $past(cnt_q) == CNT_W'(OSC_RESUME_CYC - 1);
    endproperty
    a_osc_resume: assert property (p_osc_resume) else $error("osc resume count wrong");
    property p_pdown_power;
        @(posedge clk) disable iff (reset)
        state_q == ST_PDN |-> !irc_power_en && !flash_power_en && !flash_access_en;
    endproperty
    a_pdown_power: assert property (p_pdown_power) else $error("power-down power left on");
    property p_flash_wait;
        @(posedge clk) disable iff (reset)
        $rose(flash_ready_q) && $past(flash_wait_q) |-> $past(flash_cnt_q) == CNT_W'(FLASH_WAKE_CYCLES - 1);
    endproperty
    a_flash_wait: assert property (p_flash_wait) else $error("flash released early");
    property p_dpd_entry;
        @(posedge clk) disable iff (reset)
        $rose(state_q == ST_DPD) |-> $past(pin_s_q[PIN_RTC_DPD]);
    endproperty
    a_dpd_entry: assert property (p_dpd_entry) else $error("deep power-down not from rtc");
    property p_bod1;
        @(posedge clk) disable iff (reset)
        pin_s_q[PIN_BOD1] |=> bod_irq && bod_status;
    endproperty
    a_bod1: assert property (p_bod1) else $error("brownout irq missing");

endmodule

// File: verif/pmws_cpu_model.sv
// processor core and interrupt controller model facing the sequencer
// assumes the bench holds go until the core clock stops; drives on falling edges
`timescale 1ns/100ps
module pmws_cpu_model
    import pmws_pkg::*;
#(
    parameter int N_IRQ = 32
) (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] mode,
    input wire logic [N_IRQ-1:0] mask,
    input wire logic [1:0] lag,
    input wire logic cpu_clk_en,
    output logic sleep_req,
    output logic [1:0] sleep_mode,
    output logic [N_IRQ-1:0] wake_mask,
    output logic pll_reconfig
);
    // ****************************************
    // sleep handshake
    // ****************************************
    int n;

    // one request at a time, only while the core clock runs; lag gives a slow core
    // one process owns every output, so idle values are set here first
    initial begin
        sleep_req = 1'b0;
        sleep_mode = 2'h0;
        wake_mask = '0;
        pll_reconfig = 1'b0;
        forever begin
            @(posedge clk);
            if (go && cpu_clk_en) begin
                repeat (lag) @(posedge clk);
                @(negedge clk);
                sleep_req = 1'b1;
                sleep_mode = mode;
                wake_mask = mask;
                n = 0;
                while (cpu_clk_en && n < 16) begin
                    @(negedge clk);
                    n++;
                end
                // released lines show garbage so a late capture of the mask is caught
                sleep_req = 1'b0;
                sleep_mode = ~mode;
                wake_mask = ~mask;
                n = 0;
                while (!cpu_clk_en && n < 20000) begin
                    @(negedge clk);
                    n++;
                end
                if (mode != MODE_SLEEP) begin
                    pll_reconfig = 1'b1;
                    @(negedge clk);
                    pll_reconfig = 1'b0;
                end
            end
        end
    end
endmodule

// File: verif/pmws_top_tb.sv
// self-checking bench of the power mode and wake sequencer
// assumes the core model answers sleep requests; every pin is driven on falling edges
`timescale 1ns/100ps
module pmws_top_tb
    import pmws_pkg::*;
;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    localparam int IRC_UP = 20;
    localparam int FL_UP = 40;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ext_n = 1'b1, wdt = 1'b0, bod1 = 1'b0, bod2 = 1'b0, osc_ok = 1'b0, fl_ok = 1'b0;
    logic alarm = 1'b0, dpd = 1'b0, sel_main = 1'b0, go = 1'b0;
    logic [31:0] irq = '0, mask = '0, boot_vector, wake_mask;
    logic [1:0] mode = 2'h0, lag = 2'h0, sleep_mode;
    logic sleep_req, pll_reconfig, cpu_clk_en, periph_clk_en, irc_out_en, irc_power_en, main_osc_en;
    logic pll_shutdown, cpu_div_clear, usb_div_clear, flash_power_en, flash_access_en, core_power_en;
    logic core_reset, reset_out_pin, cpu_wake, bod_irq, bod_status, clk_sel_irc;
    int fail_count = 0, comparisons = 0, seed = 72099, n, n_rc, n_main, n_pd;

    always #2 clk = ~clk;

    pmws_top #(.N_IRQ(32), .IRC_START_CYCLES(IRC_UP), .FLASH_WAKE_CYCLES(FL_UP)) dut (
        .clk(clk), .reset(reset), .ext_reset_pin_n(ext_n), .watchdog_reset(wdt),
        .brownout_stage1(bod1), .brownout_stage2(bod2), .osc_running(osc_ok),
        .flash_init_done(fl_ok), .rtc_alarm(alarm), .rtc_dpd_req(dpd), .irq_lines(irq),
        .sleep_req(sleep_req), .sleep_mode(sleep_mode), .wake_mask(wake_mask),
        .sel_main_osc(sel_main), .pll_reconfig(pll_reconfig), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .irc_out_en(irc_out_en), .irc_power_en(irc_power_en),
        .main_osc_en(main_osc_en), .pll_shutdown(pll_shutdown), .cpu_div_clear(cpu_div_clear),
        .usb_div_clear(usb_div_clear), .flash_power_en(flash_power_en),
        .flash_access_en(flash_access_en), .core_power_en(core_power_en), .core_reset(core_reset),
        .reset_out_pin(reset_out_pin), .cpu_wake(cpu_wake), .bod_irq(bod_irq),
        .bod_status(bod_status), .clk_sel_irc(clk_sel_irc), .boot_vector(boot_vector));

    pmws_cpu_model #(.N_IRQ(32)) core (.clk(clk), .go(go), .mode(mode), .mask(mask), .lag(lag),
        .cpu_clk_en(cpu_clk_en), .sleep_req(sleep_req), .sleep_mode(sleep_mode),
        .wake_mask(wake_mask), .pll_reconfig(pll_reconfig));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic exp_pwr(input logic [1:0] m);
        return m != MODE_PDOWN;
    endfunction

    // flash is only still blocked at resume when the short rc path was taken
    function automatic logic exp_flash(input logic prior_irc);
        return !prior_irc;
    endfunction

    function automatic logic probe(input int sel);
        case (sel)
            0: return cpu_clk_en;
            1: return !core_reset;
            2: return flash_access_en;
            default: return !cpu_clk_en;
        endcase
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // bounded wait on a completion flag, counting falling edges
    task automatic wait_hi(input int sel, output int cnt);
        cnt = 0;
        while (probe(sel) !== 1'b1) begin
            @(negedge clk);
            cnt++;
            if (cnt > 20000) begin
                fail_count++;
                $display("MISMATCH wait %0d expected 1 seen timeout", sel);
                report_and_stop();
            end
        end
    endtask

    // enter a low-power mode, try an unmasked line unless in sleep, then wake on a masked one
    task automatic nap(input logic [1:0] m, output int cnt);
        int idx;
        int j;
        logic prior;
        idx = {$random(seed)} % 32;
        j = (idx + 1 + {$random(seed)} % 31) % 32;
        mask = $random(seed);
        mask[idx] = 1'b1;
        mask[j] = 1'b0;
        mode = m;
        lag = 2'($random(seed));
        prior = clk_sel_irc;
        go = 1'b1;
        wait_hi(3, cnt);
        go = 1'b0;
        if (m != MODE_SLEEP) begin
            check("div_clear", {cpu_div_clear, usb_div_clear}, 2'h3);
            check("irc_out_en", irc_out_en, 1'b0);
            check("irc_power_en", irc_power_en, exp_pwr(m));
            check("flash_power_en", flash_power_en, exp_pwr(m));
            check("pll_shutdown", pll_shutdown, 1'b1);
            check("main_osc_en", main_osc_en, 1'b0);
            @(negedge clk);
            check("div_clear_end", {cpu_div_clear, usb_div_clear}, 2'h0);
            irq[j] = 1'b1;
            repeat (30) @(negedge clk);
            check("unmasked_wake", cpu_clk_en, 1'b0);
            irq[j] = 1'b0;
        end else begin
            check("periph_clk_en", periph_clk_en, 1'b1);
        end
        irq[idx] = 1'b1;
        wait_hi(0, cnt);
        check("cpu_wake", cpu_wake, 1'b1);
        irq[idx] = 1'b0;
        if (m == MODE_PDOWN) check("flash_open", flash_access_en, exp_flash(prior));
        repeat (4) @(negedge clk);
        if (m != MODE_SLEEP) check("pll_rebuilt", pll_shutdown, 1'b0);
        $display("test nap mode %0d done after %0d cycles", m, cnt);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(negedge clk);
        reset = 1'b0;
        repeat (100) @(negedge clk);
        check("core_reset_osc", core_reset, 1'b1);
        check("reset_out_held", reset_out_pin, 1'b0);
        osc_ok = 1'b1;
        fl_ok = 1'b1;
        wait_hi(1, n);
        check("boot_vector", boot_vector, 32'h0000_0000);
        check("rc_selected", clk_sel_irc, 1'b1);
        check("reset_out_high", reset_out_pin, 1'b1);
        wait_hi(0, n);
        $display("test power-up done");
        nap(MODE_SLEEP, n);
        nap(MODE_DSLEEP, n_rc);
        sel_main = 1'b1;
        @(negedge clk);
        sel_main = 1'b0;
        @(negedge clk);
        check("main_selected", clk_sel_irc, 1'b0);
        nap(MODE_DSLEEP, n_main);
        check("main_resume", n_main - n_rc, OSC_RESUME_CYC - IRC_RESUME_CYC);
        nap(MODE_PDOWN, n_pd);
        check("pd_main_resume", n_pd - n_main, IRC_UP);
        check("rc_after_pd", clk_sel_irc, 1'b1);
        nap(MODE_PDOWN, n_pd);
        check("pd_rc_resume", n_pd - n_rc, IRC_UP);
        wait_hi(2, n);
        check("flash_wait", n <= FL_UP, 1'b1);
        mode = 2'h3;
        go = 1'b1;
        repeat (24) @(negedge clk);
        check("mode3_ignored", cpu_clk_en, 1'b1);
        go = 1'b0;
        repeat (24) @(negedge clk);
        bod1 = 1'b1;
        repeat (4) @(negedge clk);
        check("bod_flags", {bod_irq, bod_status}, 2'h3);
        bod1 = 1'b0;
        repeat (4) @(negedge clk);
        check("bod_flags_off", {bod_irq, bod_status}, 2'h0);
        for (int s = 0; s < 3; s++) begin
            ext_n = (s != 0);
            wdt = (s == 1);
            bod2 = (s == 2);
            repeat (4) @(negedge clk);
            check("core_reset_src", core_reset, 1'b1);
            check("reset_out_low", reset_out_pin, 1'b0);
            ext_n = 1'b1;
            wdt = 1'b0;
            bod2 = 1'b0;
            wait_hi(1, n);
            check("hold_count", n >= RST_HOLD_CYC, 1'b1);
            check("reset_out_back", reset_out_pin, 1'b1);
            wait_hi(0, n);
        end
        $display("test reset sources done");
        dpd = 1'b1;
        repeat (4) @(negedge clk);
        dpd = 1'b0;
        repeat (4) @(negedge clk);
        check("dpd_power", core_power_en, 1'b0);
        irq = '1;
        repeat (30) @(negedge clk);
        check("dpd_irq_ignored", core_power_en, 1'b0);
        irq = '0;
        alarm = 1'b1;
        repeat (4) @(negedge clk);
        alarm = 1'b0;
        wait_hi(1, n);
        check("dpd_alarm_exit", core_power_en, 1'b1);
        $display("test deep power-down done");
        report_and_stop();
    end
endmodule
